// File: common/liu_pkg.sv
package liu_pkg;

	// ==========================================================
	// register port and map
	localparam int ADDR_W = 5;
	localparam logic [4:0] OFF_STANDARD_CFG = 5'h00;
	localparam logic [4:0] OFF_DRIVER_CFG = 5'h01;
	localparam logic [4:0] OFF_TX_PATTERN_CFG = 5'h02;
	localparam logic [4:0] OFF_LINE_CONFIG = 5'h03;
	localparam logic [4:0] OFF_CLOCK_TERM_CONFIG = 5'h04;
	localparam logic [4:0] OFF_LOOPBACK_CONFIG = 5'h05;
	localparam logic [4:0] OFF_ALARM_STATUS = 5'h06;
	localparam logic [4:0] OFF_INTERRUPT_MASK = 5'h07;
	localparam logic [4:0] OFF_RX_INFO_ONE = 5'h08;
	localparam logic [4:0] OFF_RX_INFO_TWO = 5'h09;
	localparam logic [7:0] RESET_VALUE = 8'h00;
	localparam logic [7:0] UNMAPPED_READ = 8'h00;

	// ==========================================================
	// field positions
	localparam int POS_LINE_STANDARD = 7;
	localparam int POS_TX_ALL_ONES_OFF = 7;
	localparam int POS_LINE_IF_RESET = 2;
	localparam int POS_BUILD_OUT_LO = 5;
	localparam int POS_GAIN_LIMIT = 4;
	localparam int POS_JA_SIDE = 3;
	localparam int POS_JA_DEPTH = 2;
	localparam int POS_JA_DISABLE = 1;
	localparam int POS_TX_POWER_DOWN = 0;
	localparam int POS_BP_CLOCK_LO = 6;
	localparam int POS_MONITOR_LO = 4;
	localparam int POS_RX_SYNC = 3;
	localparam int POS_TX_SYNC = 2;
	localparam int POS_TERM_LO = 0;
	localparam int POS_LOCAL_LB = 7;
	localparam int POS_REMOTE_LB = 6;
	localparam int POS_AUTO_RLB = 5;
	localparam int POS_ANALOG_LB = 4;
	localparam int POS_REC_BYPASS = 3;
	localparam int POS_ERR_SEL_LO = 0;

	// status register groups: 0 alarm, 1 info one, 2 info two
	localparam int NUM_STATUS = 3;
	localparam logic [NUM_STATUS-1:0][7:0] LATCHED_BITS = {8'h01, 8'hFC, 8'hD8};
	localparam logic [NUM_STATUS-1:0][7:0] STATUS_MAP = {8'hFF, 8'hFC, 8'hFF};
	localparam logic [7:0] CHANGE_IRQ_BITS = 8'h38;

	// ==========================================================
	// monitor gain boost in dB
	localparam logic [5:0] MON_GAIN_NONE = 6'h00;
	localparam logic [5:0] MON_GAIN_LOW = 6'h14;
	localparam logic [5:0] MON_GAIN_MID = 6'h1A;
	localparam logic [5:0] MON_GAIN_HIGH = 6'h20;

	// ==========================================================
	// timing
	localparam int CLK_KHZ = 125000;
	localparam int LOOP_CODE_PERSIST_MS = 5000;
	localparam int LOOP_CODE_PERSIST_CYCLES = CLK_KHZ * LOOP_CODE_PERSIST_MS;
	localparam int PERSIST_W = 30;

	// ==========================================================
	// types
	typedef enum logic [1:0] {SENS_12DB, SENS_43DB, SENS_30DB, SENS_36DB} sens_type;
	typedef enum logic [1:0] {BP_16M384, BP_8M192, BP_4M096, BP_2M048} bp_rate_type;
	typedef enum logic [1:0] {TERM_OFF, TERM_120, TERM_100, TERM_75} term_type;
	typedef enum logic {ARL_WAIT_UP, ARL_LOOPED} arl_state_type;

	typedef struct packed {
		logic pos;
		logic neg;
	} line_pair_type;

	typedef struct packed {
		logic loop_up;
		logic loop_down;
		logic tx_clock_loss;
		logic rx_all_ones;
		logic carrier_loss;
		logic current_limit;
		logic open_circuit;
		logic prbs_detect;
		logic [5:0] rx_info_events;
		logic [3:0] rx_level;
		logic second_tick;
	} status_in_type;

	typedef struct packed {
		logic [2:0] build_out;
		sens_type sensitivity;
		logic ja_in_tx_path;
		logic ja_short_buffer;
		logic ja_enabled;
		bp_rate_type bp_rate;
		logic [5:0] monitor_gain_db;
		logic rx_sync_clock_enable;
		logic tx_sync_clock_enable;
		term_type termination;
		logic rec_clock_bypass;
		logic remote_loop_active;
		logic [2:0] error_count_select;
		logic line_reset_pulse;
		logic tx_all_ones;
	} settings_type;

	typedef struct packed {
		logic [7:0] standard_cfg;
		logic [7:0] driver_cfg;
		logic [7:0] tx_pattern_cfg;
		logic [7:0] line_config;
		logic [7:0] clock_term_config;
		logic [7:0] loopback_config;
		logic [7:0] interrupt_mask;
		logic [NUM_STATUS-1:0][7:0] latched;
		logic [NUM_STATUS-1:0][7:0] visible;
		logic [NUM_STATUS-1:0][7:0] read_mask;
		logic [7:0] pending;
		logic [7:0] alarm_prev;
		logic line_reset_prev;
		arl_state_type arl_state;
		logic [PERSIST_W-1:0] arl_count;
		logic arl_flag;
		logic mark_phase;
		logic [7:0] rd_data;
		logic int_n;
		settings_type settings;
		line_pair_type tx_line;
		logic tx_line_oe;
		line_pair_type rx_data;
	} bank_state_type;

endpackage

// File: hdl/liu_control_status_bank.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Overview of operation
// RULE_01: reset loads all registers and status zero
// RULE_02: tx bit clear sends unframed all ones
// RULE_03: host programs controls, then toggles line reset
// RULE_04: low hard reset restores defaults, level sensitive
// RULE_05: bits 7..5 select transmit build-out
// RULE_06: gain limit and standard set sensitivity
// RULE_07: attenuator side bit and disable bypass
// RULE_08: depth bit picks 128 or 32 bits
// RULE_09: two bits pick backplane clock rate
// RULE_10: two bits pick monitor gain boost
// RULE_11: separate rx and tx sync clock enables
// RULE_12: two bits pick receive termination
// RULE_13: local loopback copies transmit into receive
// RULE_14: remote loopback sends recovered data out
// RULE_15: bypass skips attenuator for recovered clock
// RULE_16: latched bit holds until read, then clears
// RULE_17: carrier loss, all ones stay while present
// RULE_18: status write is mask refreshing selected bits
// RULE_19: host writes mask, reads, writes back
// RULE_20: each alarm bit interrupts through own enable
// RULE_21: three alarms interrupt on every state change
// RULE_22: other alarms interrupt only when becoming set
// RULE_23: power-down floats both transmit line outputs
// RULE_24: analog loopback feeds transmit to receive
// RULE_25: auto loopback follows five-second loop codes
module liu_control_status_bank #(
	parameter int LOOP_PERSIST_CYCLES = liu_pkg::LOOP_CODE_PERSIST_CYCLES
) (
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic hard_reset_n_i,
	input wire logic [liu_pkg::ADDR_W-1:0] addr_i,
	input wire logic wr_en_i,
	input wire logic rd_en_i,
	input wire logic [7:0] wr_data_i,
	output logic [7:0] rd_data_o,
	output logic int_n_o,
	input wire liu_pkg::status_in_type status_i,
	input wire liu_pkg::line_pair_type tx_data_i,
	input wire liu_pkg::line_pair_type rx_line_i,
	input wire liu_pkg::line_pair_type recovered_i,
	output liu_pkg::line_pair_type tx_line_o,
	output logic tx_line_oe_o,
	output liu_pkg::line_pair_type rx_data_o,
	output liu_pkg::settings_type settings_o
);
	import liu_pkg::*;

	// ==========================================================
	// decode helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [4:0] off);
		hit = (a == off);
	endfunction

	function automatic int status_index(input logic [ADDR_W-1:0] a);
		status_index = -1;
		if (hit(a, OFF_ALARM_STATUS)) begin
			status_index = 0;
		end else if (hit(a, OFF_RX_INFO_ONE)) begin
			status_index = 1;
		end else if (hit(a, OFF_RX_INFO_TWO)) begin
			status_index = 2;
		end
	endfunction

	function automatic logic [5:0] monitor_gain(input logic [1:0] sel);
		unique case (sel)
			2'h0: monitor_gain = MON_GAIN_NONE;
			2'h1: monitor_gain = MON_GAIN_LOW;
			2'h2: monitor_gain = MON_GAIN_MID;
			2'h3: monitor_gain = MON_GAIN_HIGH;
		endcase
	endfunction

	bank_state_type s_q;
	bank_state_type s_d;
	logic bank_reset;
	logic [PERSIST_W-1:0] persist_last;

	// either reset source returns the bank to defaults while held
	assign bank_reset = srst_i | ~hard_reset_n_i; // RULE_04
	assign persist_last = PERSIST_W'(LOOP_PERSIST_CYCLES - 1);

	// ==========================================================
	// next state
	always_comb begin
		logic [7:0] alarm_src;
		logic [NUM_STATUS-1:0][7:0] set_src;
		logic [NUM_STATUS-1:0][7:0] info;
		logic [7:0] clear_bits;
		logic [7:0] pend_set;
		logic [7:0] pend_clear;
		logic remote_lb;
		logic rx_lb_src_pos;
		int si;
		int ri;
		line_pair_type rec;
		line_pair_type tx_src;

		s_d = s_q;
		si = status_index(addr_i);
		ri = status_index(addr_i);
		pend_clear = 8'h00;

		alarm_src = {status_i.loop_up, status_i.loop_down, status_i.tx_clock_loss,
			status_i.rx_all_ones, status_i.carrier_loss, status_i.current_limit,
			status_i.open_circuit, status_i.prbs_detect};
		// loop codes latch on arrival; carrier loss and all ones latch while present
		set_src[0] = alarm_src & ~(s_q.alarm_prev & 8'hC0); // RULE_17
		set_src[1] = {status_i.rx_info_events, 2'b00};
		set_src[2] = {status_i.rx_level, 2'b00, s_q.arl_flag, status_i.second_tick};

		// ======================================================
		// register writes
		if (wr_en_i) begin
			if (hit(addr_i, OFF_STANDARD_CFG)) begin
				s_d.standard_cfg = wr_data_i;
			end
			if (hit(addr_i, OFF_DRIVER_CFG)) begin
				s_d.driver_cfg = wr_data_i;
			end
			if (hit(addr_i, OFF_TX_PATTERN_CFG)) begin
				s_d.tx_pattern_cfg = wr_data_i;
			end
			if (hit(addr_i, OFF_LINE_CONFIG)) begin
				s_d.line_config = wr_data_i;
			end
			if (hit(addr_i, OFF_CLOCK_TERM_CONFIG)) begin
				s_d.clock_term_config = wr_data_i;
			end
			if (hit(addr_i, OFF_LOOPBACK_CONFIG)) begin
				s_d.loopback_config = wr_data_i;
			end
			if (hit(addr_i, OFF_INTERRUPT_MASK)) begin
				s_d.interrupt_mask = wr_data_i;
			end
		end

		// ======================================================
		// status groups: mask write refresh, read clears latched bits
		for (int r = 0; r < NUM_STATUS; r++) begin
			info[r] = ((s_q.latched[r] & LATCHED_BITS[r]) | (set_src[r] & ~LATCHED_BITS[r]))
				& STATUS_MAP[r];
			clear_bits = 8'h00;
			if (wr_en_i && si == r) begin
				s_d.visible[r] = (wr_data_i & info[r]) | (~wr_data_i & s_q.visible[r]); // RULE_18
				s_d.read_mask[r] = wr_data_i;
			end
			if (rd_en_i && ri == r) begin
				clear_bits = s_q.read_mask[r];
			end
			// a new event in the clearing cycle survives the clear
			s_d.latched[r] = ((set_src[r] & LATCHED_BITS[r]) | (s_q.latched[r] & ~clear_bits))
				& STATUS_MAP[r]; // RULE_16
		end

		// ======================================================
		// interrupt sources
		for (int b = 0; b < 8; b++) begin
			if (CHANGE_IRQ_BITS[b]) begin
				pend_set[b] = alarm_src[b] ^ s_q.alarm_prev[b]; // RULE_21
			end else begin
				pend_set[b] = alarm_src[b] & ~s_q.alarm_prev[b]; // RULE_22
			end
		end
		if (rd_en_i && ri == 0) begin
			pend_clear = s_q.read_mask[0];
		end
		s_d.pending = pend_set | (s_q.pending & ~pend_clear);
		s_d.alarm_prev = alarm_src;
		s_d.int_n = ~|(s_q.pending & s_q.interrupt_mask); // RULE_20

		// ======================================================
		// register read data, held until the next read
		if (rd_en_i) begin
			if (ri >= 0) begin
				s_d.rd_data = s_q.visible[ri];
			end else if (hit(addr_i, OFF_STANDARD_CFG)) begin
				s_d.rd_data = s_q.standard_cfg;
			end else if (hit(addr_i, OFF_DRIVER_CFG)) begin
				s_d.rd_data = s_q.driver_cfg;
			end else if (hit(addr_i, OFF_TX_PATTERN_CFG)) begin
				s_d.rd_data = s_q.tx_pattern_cfg;
			end else if (hit(addr_i, OFF_LINE_CONFIG)) begin
				s_d.rd_data = s_q.line_config;
			end else if (hit(addr_i, OFF_CLOCK_TERM_CONFIG)) begin
				s_d.rd_data = s_q.clock_term_config;
			end else if (hit(addr_i, OFF_LOOPBACK_CONFIG)) begin
				s_d.rd_data = s_q.loopback_config;
			end else if (hit(addr_i, OFF_INTERRUPT_MASK)) begin
				s_d.rd_data = s_q.interrupt_mask;
			end else begin
				s_d.rd_data = UNMAPPED_READ;
			end
		end

		// ======================================================
		// automatic remote loopback on persistent loop codes
		if (!s_q.loopback_config[POS_AUTO_RLB]) begin
			// clearing the enable resets the circuit and drops the flag
			s_d.arl_state = ARL_WAIT_UP; // RULE_25
			s_d.arl_count = '0;
			s_d.arl_flag = 1'b0;
		end else begin
			unique case (s_q.arl_state)
				ARL_WAIT_UP: begin
					if (!status_i.loop_up) begin
						s_d.arl_count = '0;
					end else if (s_q.arl_count == persist_last) begin
						s_d.arl_count = '0;
						s_d.arl_flag = 1'b1; // RULE_25
						s_d.arl_state = ARL_LOOPED;
					end else begin
						s_d.arl_count = s_q.arl_count + 1'b1;
					end
				end
				ARL_LOOPED: begin
					if (!status_i.loop_down) begin
						s_d.arl_count = '0;
					end else if (s_q.arl_count == persist_last) begin
						s_d.arl_count = '0;
						s_d.arl_flag = 1'b0; // RULE_25
						s_d.arl_state = ARL_WAIT_UP;
					end else begin
						s_d.arl_count = s_q.arl_count + 1'b1;
					end
				end
			endcase
		end

		// ======================================================
		// decoded settings
		s_d.settings.build_out = s_q.line_config[POS_BUILD_OUT_LO +: 3]; // RULE_05
		unique case ({s_q.standard_cfg[POS_LINE_STANDARD], s_q.line_config[POS_GAIN_LIMIT]})
			2'b00: s_d.settings.sensitivity = SENS_12DB; // RULE_06
			2'b01: s_d.settings.sensitivity = SENS_43DB;
			2'b11: s_d.settings.sensitivity = SENS_30DB;
			2'b10: s_d.settings.sensitivity = SENS_36DB;
		endcase
		s_d.settings.ja_in_tx_path = s_q.line_config[POS_JA_SIDE]; // RULE_07
		s_d.settings.ja_enabled = ~s_q.line_config[POS_JA_DISABLE]; // RULE_07
		s_d.settings.ja_short_buffer = s_q.line_config[POS_JA_DEPTH]; // RULE_08
		s_d.settings.bp_rate = bp_rate_type'(s_q.clock_term_config[POS_BP_CLOCK_LO +: 2]); // RULE_09
		s_d.settings.monitor_gain_db = monitor_gain(s_q.clock_term_config[POS_MONITOR_LO +: 2]); // RULE_10
		s_d.settings.rx_sync_clock_enable = s_q.clock_term_config[POS_RX_SYNC]; // RULE_11
		s_d.settings.tx_sync_clock_enable = s_q.clock_term_config[POS_TX_SYNC]; // RULE_11
		s_d.settings.termination = term_type'(s_q.clock_term_config[POS_TERM_LO +: 2]); // RULE_12
		s_d.settings.rec_clock_bypass = s_q.loopback_config[POS_REC_BYPASS]; // RULE_15
		s_d.settings.error_count_select = s_q.loopback_config[POS_ERR_SEL_LO +: 3];
		s_d.settings.tx_all_ones = ~s_q.tx_pattern_cfg[POS_TX_ALL_ONES_OFF]; // RULE_02
		// the line reset acts once per rising edge of its control bit
		s_d.line_reset_prev = s_q.tx_pattern_cfg[POS_LINE_IF_RESET];
		s_d.settings.line_reset_pulse = s_q.tx_pattern_cfg[POS_LINE_IF_RESET]
			& ~s_q.line_reset_prev; // RULE_03

		// ======================================================
		// data path steering
		remote_lb = s_q.loopback_config[POS_REMOTE_LB] | s_q.arl_flag; // RULE_25
		s_d.settings.remote_loop_active = remote_lb;
		rx_lb_src_pos = s_q.loopback_config[POS_ANALOG_LB];
		rec = rx_lb_src_pos ? s_q.tx_line : rx_line_i; // RULE_24
		s_d.rx_data = s_q.loopback_config[POS_LOCAL_LB] ? tx_data_i : rec; // RULE_13
		tx_src = remote_lb ? recovered_i : tx_data_i; // RULE_14
		s_d.mark_phase = ~s_q.mark_phase;
		if (s_q.line_config[POS_TX_POWER_DOWN]) begin
			s_d.tx_line = '0; // RULE_23
			s_d.tx_line_oe = 1'b0;
		end else if (~s_q.tx_pattern_cfg[POS_TX_ALL_ONES_OFF]) begin
			// unframed all ones as alternating marks keeps the line balanced
			s_d.tx_line.pos = s_q.mark_phase; // RULE_02
			s_d.tx_line.neg = ~s_q.mark_phase;
			s_d.tx_line_oe = 1'b1;
		end else begin
			// local loopback leaves the transmit side untouched
			s_d.tx_line = tx_src; // RULE_13
			s_d.tx_line_oe = 1'b1;
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge clk_i) begin
		if (bank_reset) begin
			s_q <= '0; // RULE_01
			s_q.int_n <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign rd_data_o = s_q.rd_data;
	assign int_n_o = s_q.int_n;
	assign tx_line_o = s_q.tx_line;
	assign tx_line_oe_o = s_q.tx_line_oe;
	assign rx_data_o = s_q.rx_data;
	assign settings_o = s_q.settings;

endmodule
`default_nettype wire

// File: sim/liu_control_status_bank_properties.sv
`timescale 1ns/10ps
`default_nettype none
module liu_control_status_bank_properties
	import liu_pkg::*;
(
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic hard_reset_n_i,
	input wire logic [liu_pkg::ADDR_W-1:0] addr_i,
	input wire logic wr_en_i,
	input wire logic [7:0] wr_data_i,
	input wire logic [7:0] rd_data_o,
	input wire logic int_n_o,
	input wire liu_pkg::status_in_type status_i,
	input wire logic tx_line_oe_o,
	input wire liu_pkg::settings_type settings_o
);
	// ==========================================================
	// control byte mirror; settings lag it by one cycle, so compare with $past
	logic rst;
	logic ok;
	logic [1:0] rst_q;
	logic [7:0][7:0] cfg_q;
	assign rst = srst_i || !hard_reset_n_i;
	assign ok = rst_q == 2'b00;
	always_ff @(posedge clk_i) begin
		rst_q <= {rst_q[0], rst};
		if (rst) begin
			cfg_q <= '0;
		end else if (wr_en_i && addr_i < 5'h08) begin
			cfg_q[addr_i[2:0]] <= wr_data_i;
		end
	end
	function automatic logic [5:0] gain_db(input logic [1:0] c);
		return c == 2'h0 ? MON_GAIN_NONE : c == 2'h1 ? MON_GAIN_LOW :
			c == 2'h2 ? MON_GAIN_MID : MON_GAIN_HIGH;
	endfunction
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst);
	a_soft_reset_clears: assert property (disable iff (!hard_reset_n_i)
		srst_i |=> rd_data_o == RESET_VALUE && int_n_o) else $error("soft reset left state");
	a_hard_reset_clears: assert property (disable iff (srst_i)
		!hard_reset_n_i |=> rd_data_o == RESET_VALUE && int_n_o) else $error("hard reset left state");
	a_build_out_field: assert property (ok |->
		settings_o.build_out == $past(cfg_q[3][7:5])) else $error("build-out wrong");
	a_sensitivity_table: assert property (ok |-> settings_o.sensitivity ==
		($past(cfg_q[0][7]) ? ($past(cfg_q[3][4]) ? 2'h2 : 2'h3) : {1'b0, $past(cfg_q[3][4])}))
		else $error("sensitivity wrong");
	a_attenuator_fields: assert property (ok |-> settings_o.ja_in_tx_path == $past(cfg_q[3][3])
		&& settings_o.ja_short_buffer == $past(cfg_q[3][2]) && settings_o.ja_enabled != $past(cfg_q[3][1]))
		else $error("attenuator fields wrong");
	a_clock_gain_term: assert property (ok |-> settings_o.bp_rate == $past(cfg_q[4][7:6])
		&& settings_o.monitor_gain_db == gain_db($past(cfg_q[4][5:4]))
		&& settings_o.termination == $past(cfg_q[4][1:0])) else $error("clock gain term wrong");
	a_sync_clock_bits: assert property (ok |-> settings_o.rx_sync_clock_enable == $past(cfg_q[4][3])
		&& settings_o.tx_sync_clock_enable == $past(cfg_q[4][2])) else $error("sync enables wrong");
	a_all_ones_default: assert property (ok |->
		settings_o.tx_all_ones != $past(cfg_q[2][7])) else $error("all ones control wrong");
	a_bypass_and_remote: assert property (ok && $past(cfg_q[5][6]) |-> settings_o.remote_loop_active
		&& settings_o.rec_clock_bypass == $past(cfg_q[5][3])) else $error("loop controls wrong");
	a_power_down_float: assert property (ok && $past(cfg_q[3][0]) |-> !tx_line_oe_o)
		else $error("line driven while powered down");
	a_change_interrupt: assert property (ok && $changed(status_i.carrier_loss) && cfg_q[7][3]
		|-> ##[1:3] !int_n_o) else $error("carrier change raised no interrupt");
	a_masked_no_interrupt: assert property (ok && $fell(int_n_o) |-> $past(cfg_q[7]) != 8'h00)
		else $error("interrupt with all sources masked");
endmodule
bind liu_control_status_bank liu_control_status_bank_properties checks (.clk_i(clk_i),
	.srst_i(srst_i), .hard_reset_n_i(hard_reset_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
	.wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .int_n_o(int_n_o), .status_i(status_i),
	.tx_line_oe_o(tx_line_oe_o), .settings_o(settings_o));
`default_nettype wire

// File: sim/liu_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module liu_host_model
	import liu_pkg::*;
(
	input wire logic clk_i,
	input wire logic [7:0] rd_data_i,
	output logic [liu_pkg::ADDR_W-1:0] addr_o,
	output logic wr_en_o,
	output logic rd_en_o,
	output logic [7:0] wr_data_o
);
	// ==========================================================
	// host cycles; released data shows the inverse, never the old byte
	initial begin
		addr_o = '0;
		wr_en_o = 1'b0;
		rd_en_o = 1'b0;
		wr_data_o = '0;
	end
	task automatic write_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		wr_data_o <= d;
		wr_en_o <= 1'b1;
		@(posedge clk_i);
		wr_en_o <= 1'b0;
		wr_data_o <= ~d;
	endtask
	task automatic read_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk_i);
		addr_o <= a;
		rd_en_o <= 1'b1;
		@(posedge clk_i);
		rd_en_o <= 1'b0;
		#1;
		d = rd_data_i;
	endtask
	task automatic poll_status(input logic [4:0] a, input logic [7:0] m, output logic [7:0] d);
		write_reg(a, m);
		read_reg(a, d);
		write_reg(a, d & m);
	endtask
	task automatic start_up();
		write_reg(OFF_LINE_CONFIG, 8'h00);
		write_reg(OFF_CLOCK_TERM_CONFIG, 8'h00);
		write_reg(OFF_LOOPBACK_CONFIG, 8'h00);
		write_reg(OFF_TX_PATTERN_CFG, 8'h80);
		write_reg(OFF_TX_PATTERN_CFG, 8'h84);
		write_reg(OFF_TX_PATTERN_CFG, 8'h80);
	endtask
endmodule
`default_nettype wire

// File: sim/liu_control_status_bank_bench.sv
`timescale 1ns/10ps
`default_nettype none
module liu_control_status_bank_bench;
	import liu_pkg::*;
	localparam int PERSIST = 16;
	logic clk_i;
	logic srst_i;
	logic hard_reset_n_i;
	logic [ADDR_W-1:0] addr;
	logic wr_en;
	logic rd_en;
	logic [7:0] wr_data;
	logic [7:0] rd_data_o;
	logic int_n_o;
	status_in_type status_i;
	line_pair_type tx_data_i;
	line_pair_type rx_line_i;
	line_pair_type recovered_i;
	line_pair_type tx_line_o;
	logic tx_line_oe_o;
	line_pair_type rx_data_o;
	settings_type settings_o;
	int bad_count = 0;
	int tests_run = 0;
	always #4 clk_i = ~clk_i;
	liu_control_status_bank #(.LOOP_PERSIST_CYCLES(PERSIST)) uut (.clk_i(clk_i), .srst_i(srst_i),
		.hard_reset_n_i(hard_reset_n_i), .addr_i(addr), .wr_en_i(wr_en), .rd_en_i(rd_en),
		.wr_data_i(wr_data), .rd_data_o(rd_data_o), .int_n_o(int_n_o), .status_i(status_i),
		.tx_data_i(tx_data_i), .rx_line_i(rx_line_i), .recovered_i(recovered_i),
		.tx_line_o(tx_line_o), .tx_line_oe_o(tx_line_oe_o), .rx_data_o(rx_data_o),
		.settings_o(settings_o));
	liu_host_model host (.clk_i(clk_i), .rd_data_i(rd_data_o), .addr_o(addr), .wr_en_o(wr_en),
		.rd_en_o(rd_en), .wr_data_o(wr_data));
	// ==========================================================
	// helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wait_int(input logic exp);
		int n;
		n = 0;
		while (int_n_o !== exp && n < 10) begin
			settle(1);
			n++;
		end
		check("interrupt pin", {7'h00, int_n_o}, {7'h00, exp});
	endtask
	// ==========================================================
	// scenarios
	task automatic reset_values();
		logic [7:0] d;
		for (int a = 0; a < 10; a++) begin
			host.read_reg(a[4:0], d);
			check("reset byte", d, RESET_VALUE);
		end
		host.read_reg(5'h1F, d);
		check("unmapped byte", d, UNMAPPED_READ);
		check("all ones at reset", {7'h00, settings_o.tx_all_ones}, 8'h01);
		check("all ones driven", {7'h00, tx_line_oe_o}, 8'h01);
		d = {6'h00, tx_line_o};
		settle(1);
		check("all ones marks", {6'h00, tx_line_o}, {6'h00, ~d[1:0]});
	endtask
	task automatic config_tables();
		logic [5:0] gains [4] = '{MON_GAIN_NONE, MON_GAIN_LOW, MON_GAIN_MID, MON_GAIN_HIGH};
		logic [1:0] sens [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
		logic [7:0] d;
		for (int i = 0; i < 4; i++) begin
			host.write_reg(OFF_CLOCK_TERM_CONFIG, {i[1:0], i[1:0], i[0], i[1], i[1:0]});
			host.write_reg(OFF_STANDARD_CFG, {i[1], 7'h00});
			host.write_reg(OFF_LINE_CONFIG, {i[1:0], 1'b1, i[0], 4'h0});
			settle(3);
			check("backplane rate", {6'h00, settings_o.bp_rate}, i[7:0]);
			check("monitor gain", {2'h0, settings_o.monitor_gain_db}, {2'h0, gains[i]});
			check("termination", {6'h00, settings_o.termination}, i[7:0]);
			check("sync enables", {6'h00, settings_o.tx_sync_clock_enable,
				settings_o.rx_sync_clock_enable}, {6'h00, i[1:0]});
			check("build-out", {5'h00, settings_o.build_out}, {5'h00, i[1:0], 1'b1});
			check("sensitivity", {6'h00, settings_o.sensitivity}, {6'h00, sens[i]});
			host.read_reg(OFF_CLOCK_TERM_CONFIG, d);
			check("clock term byte", d, {i[1:0], i[1:0], i[0], i[1], i[1:0]});
		end
	endtask
	task automatic status_latched();
		logic [7:0] d;
		@(posedge clk_i);
		status_i.loop_up <= 1'b1;
		@(posedge clk_i);
		status_i.loop_up <= 1'b0;
		host.write_reg(OFF_ALARM_STATUS, 8'h00);
		host.read_reg(OFF_ALARM_STATUS, d);
		check("unrefreshed bit", d & 8'h80, 8'h00);
		host.poll_status(OFF_ALARM_STATUS, 8'hC0, d);
		check("latched event", d & 8'hC0, 8'h80);
		host.poll_status(OFF_ALARM_STATUS, 8'hC0, d);
		check("event cleared", d & 8'hC0, 8'h00);
		status_i.carrier_loss <= 1'b1;
		host.poll_status(OFF_ALARM_STATUS, 8'h08, d);
		check("carrier loss", d & 8'h08, 8'h08);
		host.poll_status(OFF_ALARM_STATUS, 8'h08, d);
		check("carrier loss held", d & 8'h08, 8'h08);
		status_i.carrier_loss <= 1'b0;
		host.poll_status(OFF_ALARM_STATUS, 8'hFF, d);
		host.poll_status(OFF_ALARM_STATUS, 8'hFF, d);
	endtask
	task automatic interrupts();
		logic [7:0] d;
		host.write_reg(OFF_INTERRUPT_MASK, 8'h0C);
		status_i.carrier_loss <= 1'b1;
		wait_int(1'b0);
		host.poll_status(OFF_ALARM_STATUS, 8'h08, d);
		wait_int(1'b1);
		status_i.carrier_loss <= 1'b0;
		wait_int(1'b0);
		host.poll_status(OFF_ALARM_STATUS, 8'h08, d);
		wait_int(1'b1);
		status_i.current_limit <= 1'b1;
		wait_int(1'b0);
		host.poll_status(OFF_ALARM_STATUS, 8'h04, d);
		wait_int(1'b1);
		status_i.current_limit <= 1'b0;
		status_i.prbs_detect <= 1'b1;
		settle(6);
		check("quiet on fall or masked", {7'h00, int_n_o}, 8'h01);
		status_i.prbs_detect <= 1'b0;
	endtask
	task automatic data_paths();
		tx_data_i <= 2'b10;
		rx_line_i <= 2'b01;
		recovered_i <= 2'b01;
		host.write_reg(OFF_LOOPBACK_CONFIG, 8'h80);
		settle(4);
		check("local loop rx", {6'h00, rx_data_o}, 8'h02);
		check("local loop tx", {6'h00, tx_line_o}, 8'h02);
		host.write_reg(OFF_LOOPBACK_CONFIG, 8'h40);
		settle(4);
		check("remote loop tx", {6'h00, tx_line_o}, 8'h01);
		host.write_reg(OFF_LOOPBACK_CONFIG, 8'h10);
		settle(4);
		check("analog loop rx", {6'h00, rx_data_o}, 8'h02);
		host.write_reg(OFF_LOOPBACK_CONFIG, 8'h00);
		host.write_reg(OFF_LINE_CONFIG, 8'h01);
		settle(4);
		check("driver floated", {7'h00, tx_line_oe_o}, 8'h00);
		host.write_reg(OFF_LINE_CONFIG, 8'h00);
		settle(4);
		check("driver on", {7'h00, tx_line_oe_o}, 8'h01);
	endtask
	task automatic auto_loop();
		logic [7:0] d;
		host.write_reg(OFF_LOOPBACK_CONFIG, 8'h20);
		status_i.loop_up <= 1'b1;
		settle(PERSIST / 2);
		check("loop early", {7'h00, settings_o.remote_loop_active}, 8'h00);
		settle(PERSIST);
		check("loop entered", {7'h00, settings_o.remote_loop_active}, 8'h01);
		host.poll_status(OFF_RX_INFO_TWO, 8'h02, d);
		check("loop flag", d & 8'h02, 8'h02);
		status_i.loop_up <= 1'b0;
		status_i.loop_down <= 1'b1;
		settle(PERSIST + PERSIST / 2);
		check("loop left", {7'h00, settings_o.remote_loop_active}, 8'h00);
		host.poll_status(OFF_RX_INFO_TWO, 8'h02, d);
		check("loop flag clear", d & 8'h02, 8'h00);
		status_i.loop_down <= 1'b0;
	endtask
	task automatic hard_reset();
		logic [7:0] d;
		host.write_reg(OFF_LINE_CONFIG, 8'hA5);
		@(posedge clk_i);
		hard_reset_n_i <= 1'b0;
		@(posedge clk_i);
		hard_reset_n_i <= 1'b1;
		host.read_reg(OFF_LINE_CONFIG, d);
		check("hard reset byte", d, RESET_VALUE);
		check("hard reset all ones", {7'h00, settings_o.tx_all_ones}, 8'h01);
	endtask
	initial begin
		clk_i = 1'b0;
		srst_i = 1'b1;
		hard_reset_n_i = 1'b1;
		status_i = '0;
		tx_data_i = '0;
		rx_line_i = '0;
		recovered_i = '0;
		repeat (20) @(posedge clk_i);
		srst_i <= 1'b0;
		reset_values();
		host.start_up();
		settle(3);
		check("data enabled", {7'h00, settings_o.tx_all_ones}, 8'h00);
		config_tables();
		status_latched();
		interrupts();
		data_paths();
		auto_loop();
		hard_reset();
		give_verdict();
	end
endmodule
`default_nettype wire
